/* File: rtl/pp_cfg.svh */
// constants of the parallel programming port: timing, codes, reset values
// assumes a 50 MHz master clock; included by pp_pkg and the port module
`ifndef PP_CFG_SVH
`define PP_CFG_SVH
`define PP_CLK_NS        20
`define PP_ENTRY_NS      100
`define PP_ENTRY_CYC     ((`PP_ENTRY_NS + `PP_CLK_NS - 1) / `PP_CLK_NS)
`define PP_ERASE_US      23000
`define PP_FLASH_US      12000
`define PP_BYTE_US       1500
`define PP_ERASE_CYC     (`PP_ERASE_US * 1000 / `PP_CLK_NS)
`define PP_FLASH_CYC     (`PP_FLASH_US * 1000 / `PP_CLK_NS)
`define PP_BYTE_CYC      (`PP_BYTE_US * 1000 / `PP_CLK_NS)
`define PP_CNT_W         21
`define PP_ENTRY_W       3
`define PP_FLASH_AW      13
`define PP_EE_AW         9
`define PP_PB_AW         6
`define PP_LATCH_W       15
`define PP_FIFO_DEPTH    8
`define PP_ACT_ADDR      2'h0
`define PP_ACT_DATA      2'h1
`define PP_ACT_CMD       2'h2
`define PP_ACT_IDLE      2'h3
`define PP_CMD_NOP       8'h00
`define PP_CMD_ERASE     8'h80
`define PP_CMD_WR_FUSE   8'h40
`define PP_CMD_WR_LOCK   8'h20
`define PP_CMD_WR_FLASH  8'h10
`define PP_CMD_WR_EE     8'h11
`define PP_CMD_RD_SIG    8'h08
`define PP_CMD_RD_FUSE   8'h04
`define PP_CMD_RD_FLASH  8'h02
`define PP_CMD_RD_EE     8'h03
`define PP_FUSE_LO_RST   8'hD2
`define PP_FUSE_HI_RST   3'h7
`define PP_LOCK_RST      6'h3F
`define PP_EE_TOP_ZERO   4'h0
`endif

/* File: rtl/pp_pkg.sv */
// types of the parallel programming port
// assumes pp_cfg.svh on the include path
`include "pp_cfg.svh"
package pp_pkg;
  typedef logic [`PP_CNT_W-1:0] cnt_t;
  typedef enum logic [1:0] {IDLE, ERASE, PAGE, WAIT} phase_t;
  typedef struct packed {
    phase_t                    phase;
    logic [7:0]                cmd;
    logic [7:0]                addr_hi;
    logic [7:0]                addr_lo;
    logic [7:0]                data;
    logic [7:0]                fuse_lo;
    logic [2:0]                fuse_hi;
    logic [5:0]                locks;
    logic                      xtal_q;
    logic                      page_latch_strobe_q;
    logic                      wr_n_q;
    logic                      hv_q;
    logic                      bs1_q;
    logic                      prog_mode;
    logic [`PP_ENTRY_W-1:0]    entry_cnt;
    logic                      latch_pend;
    logic [`PP_LATCH_W-1:0]    latch_word;
    logic [`PP_FLASH_AW-1:0]   walk;
    cnt_t                      count;
    logic [7:0]                dout;
    logic                      dout_oe;
    logic                      rdy;
  } state_t;
endpackage

/* File: rtl/parallel_programming_port.sv */
// parallel programming port: command/address/data loading, page buffer,
// self-timed erase and writes, flash/eeprom/signature/fuse reads.
// assumes all pins already synchronous to i_mclk; the data bus is split into
// input, output and output enable, resolved outside.
// Behaviour
// - load-clock rise captures addr, data, command
// - decode erase, fuse, lock, flash, eeprom writes
// - decode reads; write/output strobe executes command
// - ready_busy_n low while programming
// - erase clears flash, eeprom, then locks
// - write strobe starts erase, busy low
// - flash is 128 pages, page buffered
// - page latch moves byte into buffer
// - page number from high and lo[7:6]
// - write strobe programs buffered page, busy
// - no-operation command resets write signals
// - eeprom byte write, busy until done
// - command and address are retained
// - flash read drives selected byte
// - eeprom read drives addressed byte
// - three-byte read-only identification code
// - oscillator trim byte in signature space
// - signature read selects one of three
`timescale 1ns/1ps
`include "pp_cfg.svh"

module pp_fifo #(
  parameter int WIDTH = `PP_LATCH_W,
  parameter int DEPTH = `PP_FIFO_DEPTH
) (
  input  wire logic             i_mclk,
  input  wire logic             i_reset,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fifo_state_t;
  fifo_state_t s;
  fifo_state_t next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign o_in_ready  = s.cnt != (AW+1)'(DEPTH);
  assign o_out_valid = s.cnt != '0;
  assign o_out_data  = mem[s.rp];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wp = (s.wp == AW'(DEPTH-1)) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = (s.rp == AW'(DEPTH-1)) ? '0 : s.rp + 1'b1;
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[s.wp] <= i_in_data;
    end
  end
endmodule

module parallel_programming_port #(
  parameter pp_pkg::cnt_t ERASE_CYC = pp_pkg::cnt_t'(`PP_ERASE_CYC),
  parameter pp_pkg::cnt_t FLASH_CYC = pp_pkg::cnt_t'(`PP_FLASH_CYC),
  parameter pp_pkg::cnt_t BYTE_CYC  = pp_pkg::cnt_t'(`PP_BYTE_CYC),
  parameter logic [7:0]   SIG0      = 8'h5A,  // arbitrary identity value
  parameter logic [7:0]   SIG1      = 8'hA5,  // arbitrary identity value
  parameter logic [7:0]   SIG2      = 8'h3C,  // arbitrary identity value
  parameter logic [7:0]   TRIM      = 8'h80
) (
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic       i_hv_reset,
  input  wire logic       i_load_clock_pin,
  input  wire logic       i_clock_action_sel0,
  input  wire logic       i_clock_action_sel1,
  input  wire logic       i_byte_select_hi,
  input  wire logic       i_byte_select_second_hi,
  input  wire logic       i_write_n,
  input  wire logic       i_output_enable_n,
  input  wire logic       i_page_latch_strobe,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic            o_data_oe,
  output logic            o_ready_busy_n,
  output logic            o_prog_mode
);
  pp_pkg::state_t s;
  pp_pkg::state_t next_s;

  logic [15:0] flash [1 << `PP_FLASH_AW];
  logic [7:0]  eeprom [1 << `PP_EE_AW];
  logic [7:0]  pbuf_lo [1 << `PP_PB_AW];
  logic [7:0]  pbuf_hi [1 << `PP_PB_AW];

  logic                    flash_we;
  logic [`PP_FLASH_AW-1:0] flash_wa;
  logic [15:0]             flash_wd;
  logic                    ee_we;
  logic [`PP_EE_AW-1:0]    ee_wa;
  logic [7:0]              ee_wd;
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic                    fifo_out_ready;
  logic [`PP_LATCH_W-1:0]  fifo_out_data;
  logic [`PP_FLASH_AW-1:0] word_addr;
  logic [6:0]              page;
  logic [15:0]             rd_word;
  logic [7:0]              rd_byte;
  logic                    rise_x;
  logic                    rise_page_latch_strobe;
  logic                    fall_wr;
  logic                    wr_ok;

  assign word_addr = {s.addr_hi[4:0], s.addr_lo};
  assign page      = {s.addr_hi[4:0], s.addr_lo[7:6]};
  assign rd_word   = flash[word_addr];
  // the buffer may not change while a page is being copied out of it
  assign fifo_out_ready = s.phase != pp_pkg::PAGE;
  // lock bit 1 programmed forbids further memory and fuse programming
  assign wr_ok     = s.locks[0];

  pp_fifo #(
    .WIDTH(`PP_LATCH_W),
    .DEPTH(`PP_FIFO_DEPTH)
  ) u_latch_fifo (
    .i_mclk     (i_mclk),
    .i_reset    (i_reset),
    .i_in_valid (s.latch_pend),
    .o_in_ready (fifo_in_ready),
    .i_in_data  (s.latch_word),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data (fifo_out_data)
  );

  always_comb begin
    rd_byte = 8'hFF;
    unique case (s.cmd)
      `PP_CMD_RD_SIG: begin
        if (i_byte_select_hi) begin
          rd_byte = (s.addr_lo == 8'h00) ? TRIM : 8'hFF;
        end else if (s.addr_lo == 8'h00) begin
          rd_byte = SIG0;
        end else if (s.addr_lo == 8'h01) begin
          rd_byte = SIG1;
        end else if (s.addr_lo == 8'h02) begin
          rd_byte = SIG2;
        end
      end
      `PP_CMD_RD_FUSE: begin
        unique case ({i_byte_select_second_hi, i_byte_select_hi})
          2'h0: rd_byte = s.fuse_lo;
          2'h1: rd_byte = {2'h3, s.locks};
          2'h3: rd_byte = {5'h1F, s.fuse_hi};
          2'h2: rd_byte = 8'hFF;
        endcase
      end
      `PP_CMD_RD_FLASH: begin
        if (s.locks[1:0] != 2'h0) begin
          rd_byte = i_byte_select_hi ? rd_word[15:8] : rd_word[7:0];
        end
      end
      `PP_CMD_RD_EE: begin
        if (s.locks[1:0] != 2'h0 && !i_byte_select_hi) begin
          rd_byte = eeprom[{s.addr_hi[0], s.addr_lo}];
        end
      end
      default: rd_byte = 8'hFF;
    endcase
  end

  always_comb begin
    next_s   = s;
    flash_we = 1'b0;
    flash_wa = s.walk;
    flash_wd = 16'hFFFF;
    ee_we    = 1'b0;
    ee_wa    = s.walk[`PP_EE_AW-1:0];
    ee_wd    = 8'hFF;
    rise_x     = i_load_clock_pin & ~s.xtal_q;
    rise_page_latch_strobe = i_page_latch_strobe & ~s.page_latch_strobe_q;
    fall_wr    = ~i_write_n & s.wr_n_q;
    next_s.xtal_q  = i_load_clock_pin;
    next_s.page_latch_strobe_q = i_page_latch_strobe;
    next_s.wr_n_q  = i_write_n;
    next_s.hv_q    = i_hv_reset;
    next_s.bs1_q   = i_byte_select_hi;

    // entry: selects low on the high-voltage edge, then first select still
    if (!i_hv_reset) begin
      next_s.prog_mode = 1'b0;
      next_s.entry_cnt = '0;
    end else if (!s.hv_q) begin
      next_s.prog_mode = ~i_byte_select_hi & ~i_byte_select_second_hi;
      next_s.entry_cnt = `PP_ENTRY_W'(`PP_ENTRY_CYC);
    end else if (s.entry_cnt != '0) begin
      next_s.entry_cnt = s.entry_cnt - 1'b1;
      if (i_byte_select_hi != s.bs1_q) begin
        next_s.prog_mode = 1'b0;
      end
    end

    // loaded values stay until reloaded
    if (s.prog_mode && rise_x) begin
      unique case ({i_clock_action_sel1, i_clock_action_sel0})
        `PP_ACT_ADDR: begin
          if (i_byte_select_hi) begin
            next_s.addr_hi = i_data;
          end else begin
            next_s.addr_lo = i_data;
          end
        end
        `PP_ACT_DATA: next_s.data = i_data;
        `PP_ACT_CMD:  next_s.cmd = i_data;
        `PP_ACT_IDLE: next_s.data = s.data;
      endcase
    end

    // a latch waits here while the buffer queue is full
    if (s.latch_pend && fifo_in_ready) begin
      next_s.latch_pend = 1'b0;
    end
    if (s.prog_mode && rise_page_latch_strobe && s.cmd == `PP_CMD_WR_FLASH) begin
      next_s.latch_pend = 1'b1;
      next_s.latch_word = {i_byte_select_hi, s.addr_lo[5:0], s.data};
    end

    if (s.phase != pp_pkg::IDLE && s.count != '0) begin
      next_s.count = s.count - 1'b1;
    end

    unique case (s.phase)
      pp_pkg::IDLE: begin
        if (s.prog_mode && fall_wr) begin
          unique case (s.cmd)
            `PP_CMD_ERASE: begin
              next_s.phase = pp_pkg::ERASE;
              next_s.walk  = '0;
              next_s.count = ERASE_CYC;
            end
            `PP_CMD_WR_FLASH: begin
              if (wr_ok) begin
                next_s.phase = pp_pkg::PAGE;
                next_s.walk  = '0;
                next_s.count = FLASH_CYC;
              end
            end
            `PP_CMD_WR_EE: begin
              if (wr_ok && !i_byte_select_hi) begin
                ee_we        = 1'b1;
                ee_wa        = {s.addr_hi[0], s.addr_lo};
                ee_wd        = s.data;
                next_s.phase = pp_pkg::WAIT;
                next_s.count = BYTE_CYC;
              end
            end
            `PP_CMD_WR_FUSE: begin
              if (wr_ok) begin
                if (i_byte_select_hi) begin
                  next_s.fuse_hi = s.data[2:0];
                end else begin
                  next_s.fuse_lo = s.data;
                end
                next_s.phase = pp_pkg::WAIT;
                next_s.count = BYTE_CYC;
              end
            end
            `PP_CMD_WR_LOCK: begin
              // lock bits can only be programmed, never released here
              next_s.locks = s.locks & s.data[5:0];
              next_s.phase = pp_pkg::WAIT;
              next_s.count = BYTE_CYC;
            end
            default: next_s.phase = pp_pkg::IDLE;
          endcase
        end
      end
      pp_pkg::ERASE: begin
        flash_we    = 1'b1;
        ee_we       = s.walk[`PP_FLASH_AW-1:`PP_EE_AW] == `PP_EE_TOP_ZERO;
        next_s.walk = s.walk + 1'b1;
        if (s.walk == '1) begin
          next_s.locks = `PP_LOCK_RST;
          next_s.phase = pp_pkg::WAIT;
        end
      end
      pp_pkg::PAGE: begin
        flash_we    = 1'b1;
        flash_wa    = {page, s.walk[`PP_PB_AW-1:0]};
        flash_wd    = {pbuf_hi[s.walk[`PP_PB_AW-1:0]], pbuf_lo[s.walk[`PP_PB_AW-1:0]]};
        next_s.walk = s.walk + 1'b1;
        if (s.walk[`PP_PB_AW-1:0] == '1) begin
          next_s.phase = pp_pkg::WAIT;
        end
      end
      pp_pkg::WAIT: begin
        if (s.count == '0) begin
          next_s.phase = pp_pkg::IDLE;
        end
      end
    endcase

    next_s.rdy     = next_s.phase == pp_pkg::IDLE;
    next_s.dout_oe = s.prog_mode & ~i_output_enable_n;
    next_s.dout    = rd_byte;
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s         <= '0;
      s.phase   <= pp_pkg::IDLE;
      s.fuse_lo <= `PP_FUSE_LO_RST;
      s.fuse_hi <= `PP_FUSE_HI_RST;
      s.locks   <= `PP_LOCK_RST;
      s.xtal_q  <= 1'b1;
      s.page_latch_strobe_q <= 1'b1;
      s.wr_n_q  <= 1'b0;
      s.hv_q    <= 1'b1;
      s.rdy     <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (flash_we) begin
      flash[flash_wa] <= flash_wd;
    end
    if (ee_we) begin
      eeprom[ee_wa] <= ee_wd;
    end
    if (fifo_out_valid && fifo_out_ready) begin
      if (fifo_out_data[`PP_LATCH_W-1]) begin
        pbuf_hi[fifo_out_data[13:8]] <= fifo_out_data[7:0];
      end else begin
        pbuf_lo[fifo_out_data[13:8]] <= fifo_out_data[7:0];
      end
    end
  end

  assign o_data         = s.dout;
  assign o_data_oe      = s.dout_oe;
  assign o_ready_busy_n = s.rdy;
  assign o_prog_mode    = s.prog_mode;
endmodule

/* File: tb/parallel_programming_port_checker.sv */
// timing checks on the programming port pins
// bound into every port instance; sees its top-level pins only
`timescale 1ns/1ps
module parallel_programming_port_checker #(
  parameter pp_pkg::cnt_t ERASE_CYC = 1
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_hv_reset,
  input wire logic i_byte_select_hi,
  input wire logic i_write_n,
  input wire logic i_output_enable_n,
  input wire logic o_data_oe,
  input wire logic o_ready_busy_n,
  input wire logic o_prog_mode
);
  pp_pkg::cnt_t low;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // erase is the longest operation, so no busy spell may outlast it
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) low <= '0;
    else low <= o_ready_busy_n ? '0 : low + 1'b1;
  end
  a_oe_on_read: assert property (!i_output_enable_n && o_prog_mode |=> o_data_oe)
    else $error("data bus not driven during read");
  a_oe_release: assert property (i_output_enable_n |=> !o_data_oe)
    else $error("data bus kept after output enable");
  a_oe_needs_mode: assert property (!o_prog_mode |=> !o_data_oe)
    else $error("data bus driven outside programming");
  a_busy_cause: assert property ($fell(o_ready_busy_n) |-> $past(!i_write_n))
    else $error("busy without write strobe");
  a_busy_in_mode: assert property ($fell(o_ready_busy_n) |-> $past(o_prog_mode))
    else $error("busy outside programming");
  a_busy_min: assert property ($fell(o_ready_busy_n) |-> !o_ready_busy_n [*8])
    else $error("busy too short");
  a_busy_bound: assert property (low <= ERASE_CYC + 1'b1)
    else $error("busy longer than an erase");
  a_mode_entry: assert property ($rose(o_prog_mode) |-> $past(i_hv_reset) &&
      !$past(i_hv_reset, 2) && !$past(i_byte_select_hi))
    else $error("programming mode without entry");
  c_busy: cover property ($fell(o_ready_busy_n));
  c_read: cover property ($rose(o_data_oe));
  c_entry: cover property ($rose(o_prog_mode));
endmodule

bind parallel_programming_port parallel_programming_port_checker #(.ERASE_CYC(ERASE_CYC)) chk (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_hv_reset(i_hv_reset),
  .i_byte_select_hi(i_byte_select_hi), .i_write_n(i_write_n),
  .i_output_enable_n(i_output_enable_n), .o_data_oe(o_data_oe),
  .o_ready_busy_n(o_ready_busy_n), .o_prog_mode(o_prog_mode));

/* File: tb/pp_programmer.sv */
// external programmer model: drives strobes, selects and the data bus
// assumes the port's pins are sampled on the rising edge of i_mclk
`timescale 1ns/1ps
module pp_programmer #(
  parameter int P = 25
) (
  input  wire logic       i_mclk,
  input  wire logic       i_ready_busy_n,
  input  wire logic [7:0] i_dout,
  input  wire logic       i_dout_oe,
  output logic            o_hv,
  output logic            o_xtal,
  output logic [1:0]      o_act,
  output logic            o_bs1,
  output logic            o_bs2,
  output logic            o_wr_n,
  output logic            o_oe_n,
  output logic            o_page_latch_strobe,
  output logic [7:0]      o_bus
);
  logic [7:0] drv;
  logic       drv_on;
  // a released bus shows the inverse of the last byte, never a stale copy
  always_comb o_bus = i_dout_oe ? i_dout : (drv_on ? drv : ~drv);
  initial begin
    {o_hv, o_xtal, o_bs1, o_bs2, o_page_latch_strobe, drv_on} = '0;
    {o_wr_n, o_oe_n} = 2'h3;
    o_act = 2'h3;
    drv = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic enter();
    o_hv = 1'b0;
    tick(5);
    o_hv = 1'b1;
    tick(P);
  endtask
  task automatic load(input logic [1:0] a, input logic b, input logic [7:0] d);
    o_act = a;
    o_bs1 = b;
    drv = d;
    drv_on = 1'b1;
    tick(P);
    o_xtal = 1'b1;
    tick(P);
    o_xtal = 1'b0;
    tick(P);
    drv_on = 1'b0;
    o_act = 2'h3;
    tick(1);
  endtask
  task automatic latch(input logic b);
    o_bs1 = b;
    tick(P);
    o_page_latch_strobe = 1'b1;
    tick(P);
    o_page_latch_strobe = 1'b0;
    tick(P);
  endtask
  // counts busy cycles; leaves after P when the write is refused
  task automatic wr(output int n);
    n = 0;
    o_wr_n = 1'b0;
    for (int k = 0; k < 40000; k++) begin
      tick(1);
      if (k == P) o_wr_n = 1'b1;
      if (i_ready_busy_n === 1'b1 && k > P) break;
      if (i_ready_busy_n !== 1'b1) n++;
    end
  endtask
  task automatic rd(input logic b1, input logic b2, output logic [7:0] d, output logic v);
    o_bs1 = b1;
    o_bs2 = b2;
    o_oe_n = 1'b0;
    tick(P);
    d = o_bus;
    v = i_dout_oe;
    o_oe_n = 1'b1;
    o_bs2 = 1'b0;
    tick(P);
  endtask
endmodule

/* File: tb/parallel_programming_port_tb.sv */
// self-checking bench of the programming port with a programmer model
// assumes shortened write times set through the port parameters
`timescale 1ns/1ps
`include "pp_cfg.svh"
module parallel_programming_port_tb;
  localparam int EC = 9000;
  localparam int FC = 100;
  localparam int BC = 20;
  localparam logic [7:0] TR = 8'h9E;
  localparam logic [7:0] SG [3] = '{8'h61, 8'h72, 8'h43}; // arbitrary identity values
  logic        i_mclk, i_reset, hv, xt, b1, b2, wn, on, pl, oe, rdy, pm;
  logic [1:0]  act;
  logic [7:0]  bus, dq;
  logic [6:0]  pg;
  logic [15:0] img [64];
  logic [8:0]  ea [4];
  logic [7:0]  ev [4];
  int          fails = 0;
  int          n_checks = 0;
  int          n;
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  parallel_programming_port #(.ERASE_CYC(EC), .FLASH_CYC(FC), .BYTE_CYC(BC),
    .SIG0(SG[0]), .SIG1(SG[1]), .SIG2(SG[2]), .TRIM(TR)) dut (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_hv_reset(hv), .i_load_clock_pin(xt),
    .i_clock_action_sel0(act[0]), .i_clock_action_sel1(act[1]), .i_byte_select_hi(b1),
    .i_byte_select_second_hi(b2), .i_write_n(wn), .i_output_enable_n(on),
    .i_page_latch_strobe(pl), .i_data(bus), .o_data(dq), .o_data_oe(oe),
    .o_ready_busy_n(rdy), .o_prog_mode(pm));
  pp_programmer #(.P(25)) pp (
    .i_mclk(i_mclk), .i_ready_busy_n(rdy), .i_dout(dq), .i_dout_oe(oe), .o_hv(hv),
    .o_xtal(xt), .o_act(act), .o_bs1(b1), .o_bs2(b2), .o_wr_n(wn), .o_oe_n(on),
    .o_page_latch_strobe(pl), .o_bus(bus));
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", w, e, g);
    end
  endtask
  // high fuse bits read back under five set bits
  function automatic logic [7:0] hi_fuse(input logic [7:0] d);
    return {5'h1F, d[2:0]};
  endfunction
  // lock writes only ever clear bits of the reset pattern
  function automatic logic [7:0] lock_byte(input logic [7:0] d);
    return {2'h3, `PP_LOCK_RST & d[5:0]};
  endfunction
  task automatic cmd(input logic [7:0] c);
    pp.load(`PP_ACT_CMD, 1'b0, c);
  endtask
  task automatic r(input logic s1, input logic s2, input logic [7:0] e, input string w);
    logic [7:0] d;
    logic       v;
    pp.rd(s1, s2, d, v);
    chk({w, " drive"}, 16'h1, {15'h0, v});
    chk(w, {8'h00, e}, {8'h00, d});
  endtask
  task automatic w(input int e, input string s);
    pp.wr(n);
    chk(s, 16'(e), 16'(n));
    // a busy spell that never ends used up the wait bound
    if (n >= 40000) close_out();
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    void'($urandom(62));
    i_reset = 1'b1;
    repeat (3) @(negedge i_mclk);
    i_reset = 1'b0;
    pp.enter();
    chk("prog mode", 16'h1, {15'h0, pm});
    cmd(`PP_CMD_ERASE);
    w(EC + 1, "erase busy");
    cmd(`PP_CMD_RD_FUSE);
    r(0, 0, 8'hD2, "fuse low");
    r(1, 1, 8'hFF, "fuse high");
    cmd(`PP_CMD_WR_FUSE);
    pp.load(`PP_ACT_DATA, 1'b0, 8'hE2);
    w(BC + 1, "fuse busy");
    cmd(`PP_CMD_RD_FUSE);
    r(0, 0, 8'hE2, "fuse low");
    cmd(`PP_CMD_WR_FUSE);
    pp.load(`PP_ACT_IDLE, 1'b1, 8'h00);
    w(BC + 1, "fuse high busy");
    cmd(`PP_CMD_RD_FUSE);
    r(1, 1, hi_fuse(8'hE2), "fuse high");
    r(0, 1, 8'hFF, "fuse none");
    pg = 7'($urandom_range(0, 127));
    cmd(`PP_CMD_WR_FLASH);
    for (int i = 0; i < 64; i++) begin
      img[i] = (i == 0) ? 16'h5A0F : 16'($urandom()); // word 0 fixed, never the erased value
      pp.load(`PP_ACT_ADDR, 1'b0, {pg[1:0], 6'(i)});
      pp.load(`PP_ACT_DATA, 1'b0, img[i][7:0]);
      pp.latch(1'b0);
      pp.load(`PP_ACT_DATA, 1'b1, img[i][15:8]);
      pp.latch(1'b1);
    end
    pp.load(`PP_ACT_ADDR, 1'b1, {3'h0, pg[6:2]});
    w(FC + 1, "flash busy");
    cmd(`PP_CMD_NOP);
    w(0, "write after nop");
    cmd(`PP_CMD_RD_FLASH);
    for (int i = 0; i < 64; i++) begin
      pp.load(`PP_ACT_ADDR, 1'b0, {pg[1:0], 6'(i)});
      r(0, 0, img[i][7:0], "flash low");
      r(1, 0, img[i][15:8], "flash high");
    end
    pp.load(`PP_ACT_ADDR, 1'b0, {pg[1], ~pg[0], 6'h00});
    r(0, 0, 8'hFF, "other page");
    cmd(`PP_CMD_WR_EE);
    for (int k = 0; k < 4; k++) begin
      ea[k] = 9'(k * 128 + $urandom_range(0, 127));
      ev[k] = 8'($urandom());
      pp.load(`PP_ACT_ADDR, 1'b1, {7'h00, ea[k][8]});
      pp.load(`PP_ACT_ADDR, 1'b0, ea[k][7:0]);
      pp.load(`PP_ACT_DATA, 1'b0, ev[k]);
      w(BC + 1, "eeprom busy");
    end
    cmd(`PP_CMD_RD_EE);
    for (int k = 0; k < 4; k++) begin
      pp.load(`PP_ACT_ADDR, 1'b1, {7'h00, ea[k][8]});
      pp.load(`PP_ACT_ADDR, 1'b0, ea[k][7:0]);
      r(0, 0, ev[k], "eeprom");
      r(1, 0, 8'hFF, "eeprom high select");
    end
    cmd(`PP_CMD_RD_SIG);
    for (int k = 0; k < 3; k++) begin
      pp.load(`PP_ACT_ADDR, 1'b0, 8'(k));
      r(0, 0, SG[k], "signature");
    end
    pp.load(`PP_ACT_ADDR, 1'b0, 8'h00);
    r(1, 0, TR, "trim");
    cmd(`PP_CMD_WR_LOCK);
    pp.load(`PP_ACT_DATA, 1'b0, 8'hFC);
    w(BC + 1, "lock busy");
    cmd(`PP_CMD_RD_FLASH);
    pp.load(`PP_ACT_ADDR, 1'b1, {3'h0, pg[6:2]});
    pp.load(`PP_ACT_ADDR, 1'b0, {pg[1:0], 6'h00});
    r(0, 0, 8'hFF, "locked flash");
    cmd(`PP_CMD_RD_FUSE);
    r(1, 0, lock_byte(8'hFC), "locks");
    cmd(`PP_CMD_WR_EE);
    w(0, "locked write");
    cmd(`PP_CMD_ERASE);
    w(EC + 1, "erase busy");
    cmd(`PP_CMD_RD_FUSE);
    r(1, 0, 8'hFF, "locks erased");
    r(0, 0, 8'hE2, "fuse kept");
    cmd(`PP_CMD_RD_FLASH);
    r(0, 0, 8'hFF, "flash erased");
    cmd(`PP_CMD_RD_EE);
    pp.load(`PP_ACT_ADDR, 1'b1, {7'h00, ea[0][8]});
    pp.load(`PP_ACT_ADDR, 1'b0, ea[0][7:0]);
    r(0, 0, 8'hFF, "eeprom erased");
    close_out();
  end
endmodule
